// [mda_dma_arbiter.sv]
// Functional notes
// - Move all pending data within one tenure while the timer allows
// - Three priority groups, stepped in order
// - Interrupt vector channel has highest priority
// - Receive group ranks second
// - Transmit group ranks third
// - Round robin recomputed after every access
// - Exclusive priority channel favoured in groups
// - Separate serial arbiters for transmit, receive
// - Plain round robin or one top channel
// - Descriptor fetches are three DWORD bursts, one DWORD in demux no-burst mode
// - Data bursts at most fifteen DWORDs
// - Receive burst capped by consecutive sub-section
// - Demux mode bursts four DWORDs or none
// - Chain back-to-back transactions within tenure
// - Little endian default, swap bit enables
// - Swap only data, never descriptors/vectors
// - Whole DWORD transfers only
// - One shared receive queue, single threshold
// - Receive data arrives in 15 DWORD portions
// - Transmit feed starts on frame end/threshold
`timescale 1ns/1ps
`default_nettype none
module mda_dma_arbiter
  import mda_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // DMA requests
  input wire logic ivec_req,
  input wire logic [3:0] rx_req,
  input wire logic [3:0] rx_desc,
  input wire logic [15:0] rx_seg_len,
  input wire logic [7:0] rxq_level,
  input wire logic [3:0] tx_req,
  input wire logic [3:0] tx_desc,
  input wire logic [27:0] tx_space,
  // Host bus master side
  output logic bus_req,
  input wire logic bus_gnt,
  input wire logic lat_expired,
  input wire logic mst_beat,
  output logic mst_start,
  output logic [1:0] mst_grp,
  output logic [1:0] mst_chan,
  output logic mst_desc,
  output logic [3:0] mst_len,
  output logic [3:0] mst_be,
  output logic mst_done,
  input wire logic [31:0] host_rdata,
  output logic [31:0] host_wdata,
  // Receive queue and transmit queue data
  input wire logic [31:0] rxq_data,
  output logic rxq_pop,
  output logic [31:0] txq_data,
  output logic txq_push,
  // Transmit queue feed to serial channels
  input wire logic [3:0] tx_fe_present,
  input wire logic [27:0] tx_fill,
  input wire logic [3:0] tx_frame_done,
  output logic [3:0] tx_feed,
  // Serial channel service arbiters
  input wire logic [3:0] scc_tx_req,
  input wire logic [3:0] scc_rx_req,
  input wire logic scc_tx_adv,
  input wire logic scc_rx_adv,
  output logic scc_tx_any,
  output logic [1:0] scc_tx_sel,
  output logic scc_rx_any,
  output logic [1:0] scc_rx_sel
);
  // ****************************************
  // Registers
  // ****************************************
  logic [5:0] mode_r;          // Global mode bits
  logic [7:0] rxth_r;          // Receive queue threshold
  logic [31:0] txth_r;         // Forward thresholds
  logic xpri;                  // Exclusive priority on
  logic [1:0] priority_channel_select;             // Priority channel
  logic swap_en;               // Byte swap enabled
  logic demux;                 // Demux host bus mode
  logic noburst;               // Single DWORD transfers in demux mode
  assign xpri = mode_r[MDA_B_XPRI];
  assign priority_channel_select = mode_r[MDA_B_PCH +: 2];
  assign swap_en = mode_r[MDA_B_SWAP];
  assign demux = mode_r[MDA_B_DEMUX];
  assign noburst = mode_r[MDA_B_NOBURST];
  // Register writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MDA_MODE_RST;
      rxth_r <= MDA_RXTH_RST;
      txth_r <= MDA_TXTH_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        MDA_OFS_MODE: mode_r <= reg_wdata[5:0];
        MDA_OFS_RXTH: rxth_r <= reg_wdata[7:0];
        MDA_OFS_TXTH: txth_r <= reg_wdata;
        default: ; // Unmapped or read only
      endcase
    end
  end
  // ****************************************
  // Engine state
  // ****************************************
  mda_state_e state_r;         // Tenure state
  mda_grp_e grp_r;             // Group served now
  logic [1:0] chan_r;          // Channel served now
  logic desc_r;                // Descriptor transfer
  logic [3:0] len_r;           // Burst length
  logic [3:0] cnt_r;           // Beats done
  logic step_tx_r;             // Transmit group owed a turn
  logic xfer_end;              // Last beat of a burst
  logic any_req;               // Anything pending
  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MDA_OFS_MODE: reg_rdata <= {26'h0, mode_r};
        MDA_OFS_RXTH: reg_rdata <= {24'h0, rxth_r};
        MDA_OFS_TXTH: reg_rdata <= txth_r;
        MDA_OFS_STAT: reg_rdata <= {16'h0, tx_feed, len_r, step_tx_r, desc_r, chan_r, grp_r, state_r};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
  // ****************************************
  // Request qualification
  // ****************************************
  logic lvl_ok;                // Receive queue at or over threshold
  logic [3:0] rx_elig;         // Receive requests allowed
  assign lvl_ok = rxq_level >= rxth_r;
  assign rx_elig = rx_req & (rx_desc | {4{lvl_ok}});
  assign any_req = ivec_req | (|rx_elig) | (|tx_req);
  // ****************************************
  // Group arbiters
  // ****************************************
  logic rx_any;                // Receive group pending
  logic [1:0] rx_idx;          // Receive winner
  logic tx_any;                // Transmit group pending
  logic [1:0] tx_idx;          // Transmit winner
  logic rx_adv;                // Receive access finished
  logic tx_adv;                // Transmit access finished
  assign rx_adv = xfer_end && grp_r == MDA_G_RX;
  assign tx_adv = xfer_end && grp_r == MDA_G_TX;
  // Receive group, exclusive channel applies
  mda_rr_arb u_rx_grp (
    .sys_clk(sys_clk), .rst(rst), .req(rx_elig), .hp_en(xpri), .hp_sel(priority_channel_select),
    .adv(rx_adv), .any(rx_any), .gnt_idx(rx_idx)
  );
  // Transmit group, exclusive channel applies
  mda_rr_arb u_tx_grp (
    .sys_clk(sys_clk), .rst(rst), .req(tx_req), .hp_en(xpri), .hp_sel(priority_channel_select),
    .adv(tx_adv), .any(tx_any), .gnt_idx(tx_idx)
  );
  // Serial transmit and receive service, independent
  mda_rr_arb u_scc_tx (
    .sys_clk(sys_clk), .rst(rst), .req(scc_tx_req), .hp_en(xpri), .hp_sel(priority_channel_select),
    .adv(scc_tx_adv), .any(scc_tx_any), .gnt_idx(scc_tx_sel)
  );
  mda_rr_arb u_scc_rx (
    .sys_clk(sys_clk), .rst(rst), .req(scc_rx_req), .hp_en(xpri), .hp_sel(priority_channel_select),
    .adv(scc_rx_adv), .any(scc_rx_any), .gnt_idx(scc_rx_sel)
  );
  // ****************************************
  // Group choice and burst length
  // ****************************************
  mda_grp_e pick_grp;          // Group to serve next
  logic [1:0] pick_chan;       // Channel to serve next
  logic pick_desc;             // Next is a descriptor
  logic [3:0] pick_len;        // Next burst length
  logic [3:0] cap;             // Mode burst cap
  logic [3:0] lim;             // Space or segment limit
  logic [6:0] sp;              // Transmit space of winner
  // Vector first, then receive, then transmit; step lets transmit in
  always_comb begin
    pick_grp = MDA_G_TX;
    pick_chan = tx_idx;
    if (ivec_req) begin
      pick_grp = MDA_G_IVEC;
      pick_chan = 2'h0;
    end else if (rx_any && !(step_tx_r && tx_any)) begin
      pick_grp = MDA_G_RX;
      pick_chan = rx_idx;
    end else begin
      pick_grp = MDA_G_TX;
      pick_chan = tx_idx;
    end
  end
  // Burst size from mode, kind and space
  always_comb begin
    sp = tx_space[7*pick_chan +: 7];
    pick_desc = 1'b0;
    lim = MDA_PCI_MAX;
    if (pick_grp == MDA_G_RX) begin
      pick_desc = rx_desc[pick_chan];
      lim = rx_seg_len[4*pick_chan +: 4];
    end else if (pick_grp == MDA_G_TX) begin
      pick_desc = tx_desc[pick_chan];
      lim = (sp > 7'(MDA_PCI_MAX)) ? MDA_PCI_MAX : sp[3:0];
    end
    if (demux) begin
      cap = noburst ? MDA_ONE : MDA_DMX_MAX;
    end else begin
      cap = MDA_PCI_MAX;
    end
    if (pick_grp == MDA_G_IVEC) begin
      pick_len = MDA_ONE;
    end else if (pick_desc) begin
      pick_len = (demux && noburst) ? MDA_ONE : MDA_DESC_LEN;
    end else begin
      pick_len = (lim < cap) ? lim : cap;
    end
    if (pick_len == 4'h0) begin
      pick_len = MDA_ONE;
    end
  end
  // ****************************************
  // Tenure state machine
  // ****************************************
  assign xfer_end = state_r == MDA_S_XFER && mst_beat && (cnt_r + 4'h1 == len_r || lat_expired);
  // Hold the bus while work remains and the timer allows
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= MDA_S_IDLE;
    end else begin
      unique case (state_r)
        MDA_S_IDLE: if (any_req) state_r <= MDA_S_REQ;
        MDA_S_REQ: if (bus_gnt) state_r <= MDA_S_ARB;
        MDA_S_ARB: state_r <= MDA_S_XFER;
        MDA_S_XFER: begin
          if (xfer_end) begin
            if (any_req && !lat_expired && bus_gnt) begin
              state_r <= MDA_S_ARB;
            end else begin
              state_r <= MDA_S_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign bus_req = state_r != MDA_S_IDLE;
  // Latch the chosen transfer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      grp_r <= MDA_G_IVEC;
      chan_r <= 2'h0;
      desc_r <= 1'b0;
      len_r <= 4'h0;
    end else if (state_r == MDA_S_ARB) begin
      grp_r <= pick_grp;
      chan_r <= pick_chan;
      desc_r <= pick_desc;
      len_r <= pick_len;
    end
  end
  // Beat counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (state_r == MDA_S_ARB) begin
      cnt_r <= 4'h0;
    end else if (state_r == MDA_S_XFER && mst_beat) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // Group stepping: after receive, transmit gets the next slot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_tx_r <= 1'b0;
    end else if (rx_adv) begin
      step_tx_r <= 1'b1;
    end else if (tx_adv) begin
      step_tx_r <= 1'b0;
    end
  end
  // Transfer command outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mst_start <= 1'b0;
      mst_done <= 1'b0;
    end else begin
      mst_start <= state_r == MDA_S_ARB;
      mst_done <= xfer_end;
    end
  end
  assign mst_grp = grp_r;
  assign mst_chan = chan_r;
  assign mst_desc = desc_r;
  assign mst_len = len_r;
  assign mst_be = MDA_BE_ALL;
  // ****************************************
  // Data path with byte swap
  // ****************************************
  logic swap_now;              // Swap this transfer
  assign swap_now = swap_en && !desc_r && grp_r != MDA_G_IVEC;
  // Host write data from the receive queue
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_wdata <= 32'h0;
    end else begin
      host_wdata <= swap_now ? mda_swap(rxq_data) : rxq_data;
    end
  end
  assign rxq_pop = state_r == MDA_S_XFER && mst_beat && grp_r != MDA_G_TX;
  // Host read data into the transmit queue
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txq_data <= 32'h0;
      txq_push <= 1'b0;
    end else begin
      txq_push <= state_r == MDA_S_XFER && mst_beat && grp_r == MDA_G_TX;
      if (state_r == MDA_S_XFER && mst_beat) begin
        txq_data <= swap_now ? mda_swap(host_rdata) : host_rdata;
      end
    end
  end
  // ****************************************
  // Transmit feed toward serial channels
  // ****************************************
  logic [3:0] feed_go;         // Start condition per channel
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      feed_go[i] = tx_fe_present[i] || (tx_fill[7*i +: 7] > txth_r[MDA_TXTH_W*i +: 7]);
    end
  end
  // Feed holds through the frame, rechecked after each
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_feed <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (tx_frame_done[i]) begin
          tx_feed[i] <= 1'b0;
        end else if (feed_go[i]) begin
          tx_feed[i] <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  a_ivec_first: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_ARB && ivec_req |=> grp_r == MDA_G_IVEC) else $error("vector not first");
  a_rx_over_tx: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_ARB && !ivec_req && rx_any && !step_tx_r |=> grp_r == MDA_G_RX)
    else $error("receive group skipped");
  a_desc_len: assert property (@(posedge sys_clk) disable iff (rst)
    mst_start && mst_desc && !demux |-> mst_len == 4'h3) else $error("descriptor burst size");
  a_pci_cap: assert property (@(posedge sys_clk) disable iff (rst)
    mst_start |-> mst_len <= 4'hF && mst_len != 4'h0) else $error("burst too long");
  a_demux_cap: assert property (@(posedge sys_clk) disable iff (rst)
    mst_start && demux |-> mst_len <= (noburst ? 4'h1 : 4'h4)) else $error("demux burst size");
  a_rx_segment: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_ARB && pick_grp == MDA_G_RX && !pick_desc && rx_seg_len[4*pick_chan +: 4] != 4'h0
    |=> len_r <= $past(rx_seg_len[4*pick_chan +: 4])) else $error("receive burst over segment");
  a_desc_noswap: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_XFER && mst_beat && (desc_r || grp_r == MDA_G_IVEC)
    |=> txq_data == $past(host_rdata) && host_wdata == $past(rxq_data)) else $error("structure swapped");
  a_chain_b2b: assert property (@(posedge sys_clk) disable iff (rst)
    xfer_end && any_req && !lat_expired && bus_gnt |=> state_r == MDA_S_ARB ##1 mst_start)
    else $error("no back-to-back chaining");
  a_bus_held: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_XFER |-> bus_req) else $error("bus dropped mid burst");
  a_feed_start: assert property (@(posedge sys_clk) disable iff (rst)
    tx_fe_present[0] && !tx_frame_done[0] |=> tx_feed[0]) else $error("feed not started");
  a_rx_gate: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == MDA_S_ARB && !ivec_req && (rx_req & rx_desc) == 4'h0 && !lvl_ok |=> grp_r != MDA_G_RX)
    else $error("receive below threshold");
endmodule : mda_dma_arbiter
`default_nettype wire

// [mda_pkg.sv]
`default_nettype none
package mda_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] MDA_OFS_MODE = 8'h00;   // Global mode register
  localparam logic [7:0] MDA_OFS_RXTH = 8'h04;   // Receive queue threshold
  localparam logic [7:0] MDA_OFS_TXTH = 8'h08;   // Transmit forward thresholds
  localparam logic [7:0] MDA_OFS_STAT = 8'h0C;   // Status, read only
  // Mode register fields
  localparam int MDA_B_XPRI = 0;                 // exclusive_priority_enable
  localparam int MDA_B_PCH = 1;                  // priority_channel_select, 2 bits
  localparam int MDA_B_SWAP = 3;                 // Byte swap enable
  localparam int MDA_B_DEMUX = 4;                // De-multiplexed host bus mode
  localparam int MDA_B_NOBURST = 5;              // No bursts in demux mode
  localparam logic [5:0] MDA_MODE_RST = 6'h00;   // Mode reset value
  localparam logic [7:0] MDA_RXTH_RST = 8'h0F;   // Receive threshold reset value
  localparam logic [31:0] MDA_TXTH_RST = 32'h0;  // Forward thresholds reset value
  localparam int MDA_TXTH_W = 8;                 // Bits per channel threshold
  // ****************************************
  // Burst sizes in DWORDs
  // ****************************************
  localparam logic [3:0] MDA_DESC_LEN = 4'h3;    // Descriptor fetch
  localparam logic [3:0] MDA_PCI_MAX = 4'hF;     // Data burst, PCI mode
  localparam logic [3:0] MDA_DMX_MAX = 4'h4;     // Data burst, demux mode
  localparam logic [3:0] MDA_ONE = 4'h1;         // Single DWORD
  localparam logic [3:0] MDA_BE_ALL = 4'hF;      // Whole DWORD byte enables
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MDA_G_IVEC = 2'b00,
    MDA_G_RX = 2'b01,
    MDA_G_TX = 2'b10
  } mda_grp_e;
  typedef enum logic [1:0] {
    MDA_S_IDLE = 2'b00,
    MDA_S_REQ = 2'b01,
    MDA_S_ARB = 2'b10,
    MDA_S_XFER = 2'b11
  } mda_state_e;
  // Reverse the four bytes of a DWORD
  function automatic logic [31:0] mda_swap(input logic [31:0] d);
    mda_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : mda_swap
endpackage : mda_pkg
`default_nettype wire

// [mda_rr_arb.sv]
`timescale 1ns/1ps
`default_nettype none
module mda_rr_arb
  import mda_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] req,
  input wire logic hp_en,
  input wire logic [1:0] hp_sel,
  input wire logic adv,
  output logic any,
  output logic [1:0] gnt_idx
);
  // ****************************************
  // Round robin with optional priority channel
  // ****************************************
  logic [1:0] ptr_r; // Next channel first in line
  logic [1:0] cand;  // Loop candidate
  // Pick priority channel first, else first requester from pointer
  always_comb begin
    any = |req;
    gnt_idx = ptr_r;
    cand = 2'h0;
    if (hp_en && req[hp_sel]) begin
      gnt_idx = hp_sel;
    end else begin
      for (int k = 3; k >= 0; k--) begin
        cand = ptr_r + 2'(k);
        if (req[cand] && !(hp_en && cand == hp_sel)) begin
          gnt_idx = cand;
        end
      end
    end
  end
  // Pointer moves past the channel just served
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_r <= 2'h0;
    end else if (adv) begin
      ptr_r <= gnt_idx + 2'h1;
    end
  end
  a_rr_advance: assert property (@(posedge sys_clk) disable iff (rst)
    adv |=> ptr_r == $past(gnt_idx) + 2'h1) else $error("pointer not advanced");
endmodule : mda_rr_arb
`default_nettype wire

// [mda_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host bus and shared memory stand-in for the arbiter's master side
module mda_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic bus_req,
  input wire logic mst_start,
  input wire logic [3:0] mst_len,
  output logic bus_gnt,
  output logic mst_beat,
  output logic [31:0] host_rdata
);
  logic [3:0] left_r; // Beats still owed in this burst
  logic tog_r; // Wait state phase when slow
  logic [31:0] pat_r; // Memory data pattern
  // Grant follows request by one cycle; beats start after the start pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_gnt <= 1'b0;
      left_r <= 4'h0;
      tog_r <= 1'b0;
      pat_r <= 32'h0A0B0C0D;
    end else begin
      bus_gnt <= bus_req;
      tog_r <= ~tog_r;
      if (mst_start) begin
        left_r <= mst_len;
      end else if (!bus_req) begin
        left_r <= 4'h0; // Tenure over, a cut burst is dropped
      end else if (mst_beat) begin
        left_r <= left_r - 4'h1;
        pat_r <= pat_r + 32'h01010101;
      end
    end
  end
  // Slow mode inserts a wait state between beats
  assign mst_beat = (left_r != 4'h0) && (!slow || tog_r);
  // Data lines outside a beat never repeat the last word
  assign host_rdata = mst_beat ? pat_r : ~pat_r;
endmodule : mda_host_model
`default_nettype wire

// [multichannel_dma_arbiter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module multichannel_dma_arbiter_tb;
  import mda_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic sys_clk, rst, reg_wr, reg_rd, ivec_req, bus_req, bus_gnt, mst_beat, mst_start, mst_desc, mst_done;
  logic rxq_pop, txq_push, scc_tx_adv, scc_rx_adv, scc_tx_any, scc_rx_any, slow, lat_expired;
  logic [7:0] reg_addr, rxq_level;
  logic [31:0] reg_wdata, reg_rdata, host_rdata, host_wdata, rxq_data, txq_data, d;
  logic [3:0] rx_req, rx_desc, tx_req, tx_desc, mst_len, mst_be, tx_fe_present, tx_frame_done, tx_feed;
  logic [3:0] scc_tx_req, scc_rx_req, l;
  logic [15:0] rx_seg_len;
  logic [27:0] tx_space, tx_fill;
  logic [1:0] mst_grp, mst_chan, scc_tx_sel, scc_rx_sel, g, c;
  int mismatches, n_checks, cycles;
  // Design and host partner
  mda_dma_arbiter uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ivec_req,
    .rx_req, .rx_desc, .rx_seg_len, .rxq_level, .tx_req, .tx_desc, .tx_space, .bus_req, .bus_gnt,
    .lat_expired, .mst_beat, .mst_start, .mst_grp, .mst_chan, .mst_desc, .mst_len, .mst_be, .mst_done,
    .host_rdata, .host_wdata, .rxq_data, .rxq_pop, .txq_data, .txq_push, .tx_fe_present, .tx_fill,
    .tx_frame_done, .tx_feed, .scc_tx_req, .scc_rx_req, .scc_tx_adv, .scc_rx_adv, .scc_tx_any, .scc_tx_sel,
    .scc_rx_any, .scc_rx_sel);
  mda_host_model host (.sys_clk, .rst, .slow, .bus_req, .mst_start, .mst_len, .bus_gnt, .mst_beat,
    .host_rdata);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read
  // One host transaction; vector request is withdrawn once taken
  task automatic xfer(input bit keep);
    int k;
    k = 0;
    while (mst_start !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1 k++;
    end
    g = mst_grp;
    c = mst_chan;
    l = mst_len;
    check("byte enables", {28'h0, mst_be}, 32'hF);
    @(posedge sys_clk);
    ivec_req <= 1'b0;
    if (!keep) begin
      rx_req <= 4'h0;
      tx_req <= 4'h0;
    end
    while (mst_done !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      #1 k++;
    end
    d = host_wdata;
    check("transaction handshake", {31'h0, k < 400}, 32'h1);
  endtask : xfer
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    reg_read(MDA_OFS_MODE, d);
    check("mode reset", d, {26'h0, MDA_MODE_RST});
    reg_read(MDA_OFS_RXTH, d);
    check("rx threshold reset", d, {24'h0, MDA_RXTH_RST});
    reg_read(MDA_OFS_TXTH, d);
    check("forward threshold reset", d, MDA_TXTH_RST);
    reg_write(8'h40, 32'hFFFFFFFF);
    reg_read(8'h40, d);
    check("unmapped read", d, 32'h0);
    reg_write(MDA_OFS_MODE, 32'h3F);
    reg_read(MDA_OFS_MODE, d);
    check("mode write", d, 32'h3F);
  endtask : t_regs
  task automatic t_groups();
    do_reset();
    reg_write(MDA_OFS_MODE, 32'h08);
    @(posedge sys_clk);
    ivec_req <= 1'b1;
    rx_req <= 4'b0010;
    tx_req <= 4'b0001;
    xfer(1);
    check("vector first", {g, l}, {MDA_G_IVEC, 4'h1});
    check("vector unswapped", d, 32'h11223344);
    xfer(1);
    check("receive second", {g, c, l}, {MDA_G_RX, 2'h1, MDA_PCI_MAX});
    check("receive swapped", d, 32'h44332211);
    xfer(0);
    check("transmit third", {g, c}, {MDA_G_TX, 2'h0});
    check("transmit swapped", txq_data, 32'h2B2A2928);
    repeat (40) @(posedge sys_clk);
  endtask : t_groups
  task automatic t_bursts();
    logic [5:0] md [5];
    logic [3:0] sg [5];
    logic [3:0] ex [5];
    md = '{6'h00, 6'h00, 6'h00, 6'h10, 6'h30};
    sg = '{4'hF, 4'hF, 4'h6, 4'hF, 4'hF};
    ex = '{4'h3, 4'hF, 4'h6, 4'h4, 4'h1};
    do_reset();
    slow <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_write(MDA_OFS_MODE, {26'h0, md[i]});
      @(posedge sys_clk);
      rx_desc <= (i == 0) ? 4'b0100 : 4'h0;
      rx_seg_len <= {4'hF, sg[i], 8'hFF};
      rx_req <= 4'b0100;
      xfer(0);
      check("burst length", {28'h0, l}, {28'h0, ex[i]});
      repeat (40) @(posedge sys_clk);
    end
    slow <= 1'b0;
    rxq_level <= 8'h05;
    rx_req <= 4'b0100;
    repeat (10) @(posedge sys_clk);
    #1 check("below threshold idle", {31'h0, bus_req}, 32'h0);
    @(posedge sys_clk);
    tx_req <= 4'h1;
    tx_desc <= 4'h1;
    xfer(0);
    check("threshold skips receive", {g, l}, {MDA_G_TX, MDA_ONE});
    @(posedge sys_clk);
    rx_req <= 4'h0;
    tx_desc <= 4'h0;
    rxq_level <= 8'h20;
  endtask : t_bursts
  task automatic t_rr();
    do_reset();
    @(posedge sys_clk) rx_req <= 4'b0101;
    lat_expired <= 1'b1;
    xfer(1);
    check("round robin first", {30'h0, c}, 32'h0);
    check("timer ends tenure", {31'h0, bus_req}, 32'h0);
    xfer(0);
    check("round robin next", {30'h0, c}, 32'h2);
    repeat (40) @(posedge sys_clk);
    lat_expired <= 1'b0;
    reg_write(MDA_OFS_MODE, 32'h07);
    @(posedge sys_clk) rx_req <= 4'b1001;
    for (int i = 0; i < 2; i++) begin
      xfer(i == 0);
      check("priority channel", {30'h0, c}, 32'h3);
    end
    repeat (40) @(posedge sys_clk);
  endtask : t_rr
  task automatic t_scc(input logic [31:0] mode, input logic [7:0] txe, input logic [7:0] rxe);
    do_reset();
    reg_write(MDA_OFS_MODE, mode);
    @(posedge sys_clk);
    scc_tx_req <= 4'hF;
    scc_rx_req <= 4'b0110;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1 check("serial tx winner", {29'h0, scc_tx_any, scc_tx_sel}, {29'h0, 1'b1, txe[2*i+:2]});
      check("serial rx winner", {29'h0, scc_rx_any, scc_rx_sel}, {29'h0, 1'b1, rxe[2*i+:2]});
      @(posedge sys_clk);
      scc_tx_adv <= 1'b1;
      scc_rx_adv <= 1'b1;
      @(posedge sys_clk);
      scc_tx_adv <= 1'b0;
      scc_rx_adv <= 1'b0;
    end
  endtask : t_scc
  task automatic t_feed();
    reg_write(MDA_OFS_TXTH, 32'h05);
    @(posedge sys_clk) tx_fill <= 28'h5;
    repeat (2) @(posedge sys_clk);
    #1 check("feed at threshold", {28'h0, tx_feed}, 32'h0);
    @(posedge sys_clk) tx_fill <= 28'h6;
    @(posedge sys_clk);
    #1 check("feed above threshold", {28'h0, tx_feed}, 32'h1);
    @(posedge sys_clk);
    tx_frame_done <= 4'h1;
    tx_fill <= 28'h0;
    @(posedge sys_clk) tx_frame_done <= 4'h0;
    #1 check("feed after frame", {28'h0, tx_feed}, 32'h0);
    @(posedge sys_clk) tx_fe_present <= 4'h1;
    @(posedge sys_clk);
    #1 check("feed on frame end", {28'h0, tx_feed}, 32'h1);
  endtask : t_feed
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("Error watchdog expected finish seen hang");
      print_verdict();
    end
  end
  initial begin
    {reg_wr, reg_rd, ivec_req, scc_tx_adv, scc_rx_adv, slow, lat_expired} = '0;
    {reg_addr, reg_wdata, rx_req, rx_desc, tx_req, tx_desc, tx_fe_present, tx_frame_done, tx_fill} = '0;
    {scc_tx_req, scc_rx_req} = '0;
    rst = 1'b1;
    rxq_level = 8'h20;
    rx_seg_len = 16'hFFFF;
    tx_space = 28'hFFFFFFF;
    rxq_data = 32'h11223344;
    do_reset();
    t_regs();
    t_groups();
    t_bursts();
    t_rr();
    t_scc(32'h0, 8'b11100100, 8'b10011001);
    t_scc(32'h05, 8'b10101010, 8'b10101010);
    t_feed();
    print_verdict();
  end
endmodule : multichannel_dma_arbiter_tb
`default_nettype wire
